// file: include/dif_engine_defs.svh
// Constants for the block integrity field engine.
`ifndef DIF_ENGINE_DEFS_SVH
`define DIF_ENGINE_DEFS_SVH
`define DIF_POLY 16'h8bb7
`define DIF_FIELD_BYTES 4'h8
`define DIF_BS_512 2'h0
`define DIF_BS_520 2'h1
`define DIF_BS_4096 2'h2
`define DIF_BS_4104 2'h3
`define DIF_BLOCK_512 13'h0200
`define DIF_BLOCK_520 13'h0208
`define DIF_BLOCK_4096 13'h1000
`define DIF_BLOCK_4104 13'h1008
`define DIF_SEED_INV 16'hffff
`define REG_CTRL 12'h000
`define REG_BLKCFG 12'h004
`define REG_XFER 12'h008
`define REG_SRC_REF 12'h00c
`define REG_DST_REF 12'h010
`define REG_SRC_APP 12'h014
`define REG_DST_APP 12'h018
`define REG_STATUS 12'h01c
`define REG_DONE_BYTES 12'h020
`define REG_FIN_REF 12'h024
`define REG_FIN_APP 12'h028
`define REG_DST_LEN 12'h02c
`define REG_SRC_FIN_REF 12'h030
`define REG_SRC_FIN_APP 12'h034
`define CTRL_START_BIT 0
`define CTRL_INSERT_BIT 1
`endif

// file: include/dif_engine_pkg.sv
// Types shared by the block integrity field engine.
package dif_engine_pkg;
	typedef enum logic [1:0] {OP_CHECK, OP_INSERT} dif_op_e;
	typedef enum logic [1:0] {FAIL_NONE, FAIL_GUARD, FAIL_APP, FAIL_REF} dif_fail_e;
	// Per-operation flags set by the descriptor.
	typedef struct packed {
		logic chk_guard;
		logic chk_app;
		logic chk_ref;
		logic inv_seed;
		logic inv_result;
		logic src_ref_inc;
		logic src_app_inc;
		logic dst_ref_inc;
		logic dst_app_inc;
		logic ref_pass;
		logic app_pass;
	} dif_flags_s;
	// One byte on a data stream.
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} dif_byte_s;
endpackage

// file: core/dif_guard_crc.sv
// Byte-serial 16-bit guard CRC stage.
`timescale 1ns/1ps
`default_nettype none
`include "dif_engine_defs.svh"
module dif_guard_crc (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Control.
	input wire logic clear,
	input wire logic [15:0] seed,
	input wire logic byte_en,
	input wire logic [7:0] byte_in,
	// Running remainder.
	output logic [15:0] crc
);
	// One byte step, most significant bit first.
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ `DIF_POLY) : (r << 1);
		end
		return r;
	endfunction
	// Seeding the register equals xoring the seed into the first 16 data bits.
	always_ff @(posedge core_clk) begin
		if (rst || clear) begin
			crc <= rst ? 16'h0000 : seed;
		end else if (byte_en) begin
			crc <= crc_step(crc, byte_in);
		end
	end
endmodule
`default_nettype wire

// file: core/dif_protection_engine.sv
// Block integrity field check and insert engine with an AHB-Lite register port.
// Functional notes
// - Blocks are 512, 520, 4096 or 4104 bytes; an 8-byte field follows each.
// - Field is guard 16 bits, application tag 16, reference tag 32.
// - Guard is CRC-16 with generator 0x18bb7 over block data.
// - Guard covers block data only, never the 8 field bytes.
// - All tags move big-endian, most significant byte first.
// - Reference tag starts at seed; fixed keeps it, incrementing adds one per block.
// - An incremented tag that overflows wraps to zero.
// - Final tag values reported are those for the block after the last done.
// - Source and destination keep separate seeds and increment controls.
// - Reference passthrough copies source reference tag, ignoring destination settings; code sends field_in, which only a check op loads.
// - Application tag behaves like reference tag from its own seed.
// - Application mask ones force tag bits to zero, zeros keep them.
// - Mask is applied after increment, so blocks may share a tag.
// - Separate source and destination masks plus application passthrough flag.
// - Comparing guard equals a zero remainder over data plus guard.
// - Guard seed is zero, or all ones when invert-seed is set.
// - Invert-result inverts computed guard before compare or store.
// - Check verifies selected guard and tags per block, then advances source tags.
// - Insert writes block data then assembled field, then advances destination tags.
// - Insert destination length is transfer size plus eight per block.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dif_engine_defs.svh"
module dif_protection_engine
	import dif_engine_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Source byte stream from the memory read path.
	input wire dif_byte_s src_byte,
	input wire logic src_valid,
	output logic src_ready,
	// Destination byte stream to the memory write path.
	output dif_byte_s dst_byte,
	output logic dst_valid,
	input wire logic dst_ready
);
	typedef enum {ST_IDLE, ST_DATA, ST_FIELD, ST_EMIT, ST_JUDGE, ST_DONE} state_e;
	state_e state;
	// Descriptor registers.
	dif_flags_s flags;
	logic insert_op;
	logic [1:0] bs_sel;
	logic [31:0] xfer_size;
	logic [31:0] src_ref_seed, dst_ref_seed;
	logic [15:0] src_app_seed, dst_app_seed, src_app_mask, dst_app_mask;
	// Running state.
	logic [31:0] src_ref, dst_ref;
	logic [15:0] src_app, dst_app;
	logic [12:0] blk_cnt;
	logic [3:0] fld_cnt;
	logic [31:0] done_bytes, dst_len;
	logic [63:0] field_in;
	dif_fail_e fail;
	logic busy, done;
	logic crc_clear;
	logic [15:0] crc;
	logic [15:0] guard;
	logic [63:0] field_out;
	logic [12:0] blk_len;
	logic [31:0] blocks;
	logic src_fire, dst_fire;
	logic op_ins;
	// Bus address phase capture.
	logic wr_pend, rd_pend;
	logic [11:0] addr_q;
	logic start;

	// Decoded block size, shared by counting and length arithmetic.
	function automatic logic [12:0] block_bytes(input logic [1:0] sel);
		unique case (sel)
			`DIF_BS_512: return `DIF_BLOCK_512;
			`DIF_BS_520: return `DIF_BLOCK_520;
			`DIF_BS_4096: return `DIF_BLOCK_4096;
			`DIF_BS_4104: return `DIF_BLOCK_4104;
		endcase
	endfunction
	// Next tag: incrementing wraps to zero by natural overflow.
	function automatic logic [31:0] next_tag(input logic [31:0] t, input logic inc);
		return inc ? t + 32'h0000_0001 : t;
	endfunction
	assign blk_len = block_bytes(bs_sel);
	// A check source carries a field after every block, so its stride is eight bytes longer.
	// The mode bit is taken from the starting write itself, since the register lands on that edge.
	assign op_ins = start ? hwdata[`CTRL_INSERT_BIT] : insert_op;
	assign blocks = xfer_size / {19'h00000, (op_ins ? blk_len : blk_len + 13'h0008)};

	// Guard seed and result conditioning.
	dif_guard_crc u_crc (
		.core_clk(core_clk),
		.rst(rst),
		.clear(crc_clear),
		.seed(flags.inv_seed ? `DIF_SEED_INV : 16'h0000),
		.byte_en(src_fire && state == ST_DATA),
		.byte_in(src_byte.data),
		.crc(crc)
	);
	assign guard = flags.inv_result ? ~crc : crc;
	assign crc_clear = (state == ST_IDLE) || (state == ST_JUDGE) || (state == ST_EMIT && dst_fire
		&& fld_cnt == 4'h7);

	// Assembled destination field, application tag masked after any increment.
	always_comb begin
		field_out[63:48] = guard;
		field_out[47:32] = (flags.app_pass ? field_in[47:32] : dst_app) & ~dst_app_mask;
		field_out[31:0] = flags.ref_pass ? field_in[31:0] : dst_ref;
	end

	// Stream handshakes: source accepted in data and field phases.
	assign src_fire = src_valid && src_ready;
	assign dst_fire = dst_valid && dst_ready;
	always_comb begin
		src_ready = 1'b0;
		if (state == ST_DATA) begin
			src_ready = !insert_op || !dst_valid || dst_ready;
		end else if (state == ST_FIELD) begin
			src_ready = 1'b1;
		end
	end
	// Hold the stream port steady; destination outputs come from flip-flops.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dst_valid <= 1'b0;
			dst_byte <= '0;
		end else if (state == ST_DATA && insert_op && src_fire) begin
			dst_valid <= 1'b1;
			dst_byte <= '{data: src_byte.data, last: 1'b0};
		end else if (state == ST_EMIT && (!dst_valid || dst_ready)) begin
			dst_valid <= 1'b1;
			dst_byte.data <= field_out[8'(63 - 8 * fld_cnt) -: 8];
			dst_byte.last <= (fld_cnt == 4'h7) && (done_bytes + {19'h00000, blk_len}
				>= blocks * {19'h00000, blk_len});
		end else if (dst_fire) begin
			dst_valid <= 1'b0;
		end
	end

	// Sequencer over blocks and fields.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			blk_cnt <= 13'h0000;
			fld_cnt <= 4'h0;
		end else begin
			unique case (state)
				ST_IDLE: if (start) begin
					state <= (blocks == 32'h0) ? ST_DONE : ST_DATA;
					blk_cnt <= 13'h0000;
				end
				ST_DATA: if (src_fire) begin
					blk_cnt <= blk_cnt + 13'h0001;
					if (blk_cnt == blk_len - 13'h0001) begin
						fld_cnt <= 4'h0;
						state <= insert_op ? ST_EMIT : ST_FIELD;
					end
				end
				ST_FIELD: if (src_fire) begin
					fld_cnt <= fld_cnt + 4'h1;
					if (fld_cnt == `DIF_FIELD_BYTES - 4'h1) begin
						state <= ST_JUDGE;
					end
				end
				ST_EMIT: if (!dst_valid || dst_ready) begin
					fld_cnt <= fld_cnt + 4'h1;
					if (fld_cnt == `DIF_FIELD_BYTES - 4'h1) begin
						state <= ST_JUDGE;
					end
				end
				ST_JUDGE: begin
					blk_cnt <= 13'h0000;
					if (fail != FAIL_NONE || done_bytes >= (blocks - 32'h1)
						* {19'h00000, (insert_op ? blk_len : blk_len + 13'h0008)}) begin
						state <= ST_DONE;
					end else begin
						state <= ST_DATA;
					end
				end
				ST_DONE: if (!dst_valid) begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Source field capture, shifted in big-endian.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			field_in <= 64'h0;
		end else if (state == ST_FIELD && src_fire) begin
			field_in <= {field_in[55:0], src_byte.data};
		end
	end

	// Per-block verdict, guard first; the comparison of guards equals a zero remainder.
	dif_fail_e next_fail;
	always_comb begin
		next_fail = FAIL_NONE;
		if (!insert_op) begin
			if (flags.chk_guard && field_in[63:48] != guard) begin
				next_fail = FAIL_GUARD;
			end else if (flags.chk_app && field_in[47:32] != (src_app & ~src_app_mask)) begin
				next_fail = FAIL_APP;
			end else if (flags.chk_ref && field_in[31:0] != src_ref) begin
				next_fail = FAIL_REF;
			end
		end
	end

	// Tags, completion figures and failure type.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{src_ref, dst_ref, src_app, dst_app} <= '0;
			done_bytes <= 32'h0;
			fail <= FAIL_NONE;
		end else if (state == ST_IDLE && start) begin
			src_ref <= src_ref_seed;
			dst_ref <= dst_ref_seed;
			src_app <= src_app_seed;
			dst_app <= dst_app_seed;
			done_bytes <= 32'h0;
			fail <= FAIL_NONE;
		end else if (state == ST_JUDGE) begin
			fail <= next_fail;
			if (next_fail == FAIL_NONE) begin
				done_bytes <= done_bytes + {19'h00000, insert_op ? blk_len : blk_len + 13'h0008};
				if (insert_op) begin
					dst_ref <= next_tag(dst_ref, flags.dst_ref_inc);
					dst_app <= 16'(next_tag({16'h0000, dst_app}, flags.dst_app_inc));
				end else begin
					src_ref <= next_tag(src_ref, flags.src_ref_inc);
					src_app <= 16'(next_tag({16'h0000, src_app}, flags.src_app_inc));
				end
			end
		end
	end

	// Busy and done status; insert destination length.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			dst_len <= 32'h0;
		end else if (state == ST_IDLE && start) begin
			busy <= 1'b1;
			done <= 1'b0;
			dst_len <= xfer_size + ((xfer_size / {19'h00000, blk_len}) << 3);
		end else if (state == ST_DONE && !dst_valid) begin
			busy <= 1'b0;
			done <= 1'b1;
		end
	end

	// AHB-Lite address phase; the slave is always ready and answers OKAY.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q <= 12'h000;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			rd_pend <= hsel && htrans[1] && !hwrite;
			addr_q <= haddr;
		end
	end
	assign start = wr_pend && addr_q == `REG_CTRL && hwdata[`CTRL_START_BIT] && !busy;

	// Register writes; descriptor fields are locked while an operation runs.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{flags, insert_op, bs_sel, xfer_size} <= '0;
			{src_ref_seed, dst_ref_seed} <= '0;
			{src_app_seed, src_app_mask, dst_app_seed, dst_app_mask} <= '0;
		end else if (wr_pend && !busy) begin
			unique case (addr_q)
				`REG_CTRL: insert_op <= hwdata[`CTRL_INSERT_BIT];
				`REG_BLKCFG: {flags, bs_sel} <= hwdata[12:0];
				`REG_XFER: xfer_size <= hwdata;
				`REG_SRC_REF: src_ref_seed <= hwdata;
				`REG_DST_REF: dst_ref_seed <= hwdata;
				`REG_SRC_APP: {src_app_mask, src_app_seed} <= hwdata;
				`REG_DST_APP: {dst_app_mask, dst_app_seed} <= hwdata;
				default: ;
			endcase
		end
	end

	// Read data; unmapped addresses read as zero.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hrdata <= 32'h0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr)
				`REG_CTRL: hrdata <= {30'h0, insert_op, busy};
				`REG_BLKCFG: hrdata <= {19'h0, flags, bs_sel};
				`REG_XFER: hrdata <= xfer_size;
				`REG_SRC_REF: hrdata <= src_ref_seed;
				`REG_DST_REF: hrdata <= dst_ref_seed;
				`REG_SRC_APP: hrdata <= {src_app_mask, src_app_seed};
				`REG_DST_APP: hrdata <= {dst_app_mask, dst_app_seed};
				`REG_STATUS: hrdata <= {28'h0, 2'(fail), busy, done};
				`REG_DONE_BYTES: hrdata <= done_bytes;
				`REG_FIN_REF: hrdata <= insert_op ? dst_ref : src_ref;
				`REG_FIN_APP: hrdata <= {16'h0, insert_op ? dst_app : src_app};
				`REG_DST_LEN: hrdata <= dst_len;
				default: hrdata <= 32'h0;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: verification/dif_engine_chk.sv
// Concurrent checks on the ports of the integrity field engine.
`timescale 1ns/1ps
`default_nettype none
module dif_engine_chk
	import dif_engine_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Register port.
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Byte streams.
	input wire dif_byte_s src_byte,
	input wire logic src_valid,
	input wire logic src_ready,
	input wire dif_byte_s dst_byte,
	input wire logic dst_valid,
	input wire logic dst_ready
);
	logic rd, wp, ins;
	logic [11:0] wa;
	logic [31:0] ts, bs;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	assign rd = hsel && htrans[1] && !hwrite && hready;
	// Mirrors the size and mode writes, so the output length and echo can be predicted.
	always_ff @(posedge core_clk) begin
		wp <= hsel && htrans[1] && hwrite && hready;
		wa <= haddr;
		if (rst) begin
			ts <= 32'h0;
			bs <= 32'h200;
			ins <= 1'b0;
		end else if (wp && wa == 12'h008) begin
			ts <= hwdata;
		end else if (wp && wa == 12'h004) begin
			bs <= hwdata[1] ? (hwdata[0] ? 32'h1008 : 32'h1000) : (hwdata[0] ? 32'h208 : 32'h200);
		end else if (wp && wa == 12'h000) begin
			ins <= hwdata[1];
		end
	end
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response is not okay");
	a_reset_clear: assert property ($fell(rst) |-> !dst_valid && hrdata == 32'h0 && hreadyout)
		else $error("outputs not cleared by reset");
	a_dst_hold: assert property (dst_valid && !dst_ready |=> dst_valid && $stable(dst_byte))
		else $error("output byte lost or changed while stalled");
	a_no_skid: assert property (dst_valid && !dst_ready |-> !(src_valid && src_ready))
		else $error("source byte taken while output is stalled");
	a_data_echo: assert property (ins && src_valid && src_ready |=> dst_valid && dst_byte.data == $past(src_byte.data))
		else $error("block data not echoed one cycle later");
	a_last_gap: assert property (dst_valid && dst_ready && dst_byte.last |=> !dst_valid [*2])
		else $error("output continues after the final field byte");
	a_dst_len: assert property (rd && haddr == 12'h02c |=> hrdata == ts + ((ts / bs) << 3))
		else $error("insert destination length wrong");
	a_unmapped_zero: assert property (rd && haddr > 12'h034 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (!$past(rd) |-> $stable(hrdata))
		else $error("read data changed without a read");
endmodule
bind dif_protection_engine dif_engine_chk chk (.core_clk(core_clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.src_byte(src_byte), .src_valid(src_valid), .src_ready(src_ready), .dst_byte(dst_byte),
	.dst_valid(dst_valid), .dst_ready(dst_ready));
`default_nettype wire

// file: verification/dif_mem_side.sv
// Memory read and write path model facing the engine's byte streams.
`timescale 1ns/1ps
`default_nettype none
module dif_mem_side
	import dif_engine_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Job from the bench.
	input wire logic start,
	input wire logic [15:0] len,
	// Source stream.
	output dif_byte_s src_byte = '0,
	output logic src_valid = 1'b0,
	input wire logic src_ready,
	// Destination stream.
	output logic dst_ready = 1'b0
);
	logic [7:0] mem [0:16383];
	logic [15:0] idx;
	// Bytes go out in ascending order with random gaps; an idle line toggles so no stale byte passes.
	always @(posedge core_clk) begin
		dst_ready <= ($urandom_range(0, 3) != 0);
		if (rst || start) begin
			src_valid <= 1'b0;
			idx <= 16'h0;
		end else if (!src_valid || src_ready) begin
			if (idx < len && $urandom_range(0, 3) != 0) begin
				src_valid <= 1'b1;
				src_byte <= '{data: mem[idx], last: (idx == len - 16'h1)};
				idx <= idx + 16'h1;
			end else begin
				src_valid <= 1'b0;
				src_byte <= ~src_byte;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the integrity field engine.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import dif_engine_pkg::*;
;
	logic core_clk, rst, hsel, hwrite, hreadyout, hresp, src_valid, src_ready;
	logic dst_valid, dst_ready, start, dph;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	logic [15:0] len;
	dif_byte_s src_byte, dst_byte;
	logic [31:0] rd_q[$];
	dif_byte_s dst_q[$];
	int error_cnt, checks;
	dif_protection_engine dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_byte(src_byte),
		.src_valid(src_valid), .src_ready(src_ready), .dst_byte(dst_byte),
		.dst_valid(dst_valid), .dst_ready(dst_ready));
	dif_mem_side far (.core_clk(core_clk), .rst(rst), .start(start), .len(len),
		.src_byte(src_byte), .src_valid(src_valid), .src_ready(src_ready),
		.dst_ready(dst_ready));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// MSB-first guard remainder, one byte at a time.
	function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
		for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8bb7 : 16'h0);
		return c;
	endfunction
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c,
		output logic [31:0] q);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		dph <= c && !w;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		q = hrdata;
		dph <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 1'b0, q);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0, 1'b1, q);
	endtask
	// The bench's expected read and output byte queues are drained here as reads and output bytes appear.
	always @(posedge core_clk) begin
		if (dph && hreadyout && rd_q.size() > 0) check("register", hrdata, rd_q.pop_front());
		if (dst_valid && dst_ready && dst_q.size() == 0) check("extra byte", 32'h1, 32'h0);
		else if (dst_valid && dst_ready) check("out byte", 32'(dst_byte), 32'(dst_q.pop_front()));
	end
	// One operation: builds memory and expectations, runs it, then reads the results back.
	task automatic run_op(input logic ins, input int k, input int nb, input dif_flags_s f,
		input logic [31:0] rs, input logic [15:0] as, input logic [15:0] am, input int bad,
		input int kind);
		int bs, p, ts, eb;
		logic [15:0] g, ap, af, sd;
		logic [31:0] r, rf, q;
		logic [63:0] fld;
		bs = (k == 0) ? 512 : (k == 1) ? 520 : (k == 2) ? 4096 : 4104;
		eb = (kind != 0 && f[11 - kind]) ? bad : nb;
		p = 0;
		r = rs;
		ap = as;
		for (int b = 0; b <= nb; b++) begin
			if (b == eb) begin
				rf = r;
				af = ap;
			end
			if (b == nb) break;
			sd = f.inv_seed ? 16'hffff : 16'h0;
			g = 16'h0;
			for (int i = 0; i < bs; i++) begin
				far.mem[p] = 8'($urandom);
				// The seed is folded into the first two data bytes instead of being preloaded.
				g = crc_b(g, far.mem[p] ^ ((i == 0) ? sd[15:8] : (i == 1) ? sd[7:0] : 8'h00));
				if (ins) dst_q.push_back(dif_byte_s'({far.mem[p], 1'b0}));
				p++;
			end
			fld = {f.inv_result ? ~g : g, ap & ~am, r};
			if (b == bad && kind != 0) fld[(kind == 1) ? 63 : (kind == 2) ? 47 : 0] ^= 1'b1;
			for (int i = 7; i >= 0; i--) begin
				if (ins) dst_q.push_back(dif_byte_s'({fld[8 * i +: 8], b == nb - 1 && i == 0}));
				else begin
					far.mem[p] = fld[8 * i +: 8];
					p++;
				end
			end
			if (ins ? f.dst_ref_inc : f.src_ref_inc) r++;
			if (ins ? f.dst_app_inc : f.src_app_inc) ap++;
		end
		ts = ins ? bs * nb + 5 : (bs + 8) * nb;
		wr(12'h004, {19'h0, f, 2'(k)});
		wr(12'h008, 32'(ts));
		wr(ins ? 12'h010 : 12'h00c, rs);
		wr(ins ? 12'h00c : 12'h010, ~rs);
		wr(ins ? 12'h018 : 12'h014, {am, as});
		wr(ins ? 12'h014 : 12'h018, {~am, ~as});
		len <= 16'(ts);
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		wr(12'h000, {30'h0, ins, 1'b1});
		q = 32'h2;
		for (int n = 0; q[1] && n < 20000; n++) bus(1'b0, 12'h01c, 32'h0, 1'b0, q);
		if (q[1]) check("busy timeout", 32'h1, 32'h0);
		if (q[1]) tally_and_finish();
		rdc(12'h01c, {28'h0, (eb < nb) ? 2'(kind) : 2'h0, 2'h1});
		rdc(12'h020, 32'(ins ? bs * eb : (bs + 8) * eb));
		rdc(12'h024, rf);
		rdc(12'h028, {16'h0, af});
		if (ins) rdc(12'h02c, 32'(ts + ts / bs * 8));
		$display("test done insert %0d block %0d fault %0d", ins, bs, kind);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Main sequence: reset, register map, good checks, faults, inserts.
	initial begin
		dif_flags_s f;
		rst = 1'b1;
		{hsel, haddr, htrans, hwrite, hsize, hwdata, start, len, dph} = '0;
		void'($urandom(32'h693723c1));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rdc(12'h01c, 32'h0);
		wr(12'h100, 32'hffffffff);
		rdc(12'h100, 32'h0);
		$display("test done register map");
		for (int k = 0; k < 4; k++) run_op(1'b0, k, 2, dif_flags_s'({3'h7, 8'($urandom)}),
			(k == 0) ? 32'hffffffff : $urandom, 16'($urandom), 16'h0, 2, 0);
		for (int k = 0; k < 6; k++) begin
			f = dif_flags_s'(11'($urandom));
			if (f[10:8] == 3'h0) f.chk_ref = 1'b1;
			run_op(1'b0, 0, 3, f, $urandom, 16'($urandom), 16'h0, 1, k % 3 + 1);
		end
		run_op(1'b1, 0, 2, dif_flags_s'(11'h0fc), 32'hffffffff, 16'h0fff, 16'hf000, 2, 0);
		run_op(1'b1, 3, 1, dif_flags_s'(11'h030), $urandom, 16'($urandom), 16'h0, 1, 0);
		@(posedge core_clk);
		check("queues left", 32'(dst_q.size() + rd_q.size()), 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
